// ==== rtl/epsrs_pkg.sv ====
// constants and types for the power-state and reset supervisor
package epsrs_pkg;
  localparam int CLK_HZ = 40000000;
  // register byte offsets
  localparam logic [7:0] OFS_OP_CONFIG = 8'h00;
  localparam logic [7:0] OFS_OP_STATUS = 8'h04;
  localparam logic [7:0] OFS_SW_RESET = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STAGE_EN = 8'h10;
  localparam logic [7:0] OFS_IGN_EN = 8'h14;
  localparam logic [7:0] OFS_DIAG = 8'h18;
  // operation config fields
  localparam int CFG_PDT_LSB = 0;
  localparam int PDT_W = 8;
  localparam int CFG_AR_BIT = 8;
  localparam int CFG_AE_BIT = 9;
  localparam int CFG_WATCHDOG_RESET_ENABLE_BIT = 10;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // command register: bit 0 wake clear enable
  localparam int CMD_WAKE_CLEAR_COMMAND_BIT_BIT = 0;
  localparam logic [31:0] CMD_RESET = 32'h0000_0001;
  localparam int NUM_CH = 24;
  localparam int NUM_IGN = 4;
  // power-down timer unit: 1 ms per field count
  localparam int PDT_UNIT_US = 1000;
  localparam int PDT_UNIT_CYC = CLK_HZ / 1000000 * PDT_UNIT_US;
  // power-up reset delay
  localparam int TPUR_US = 10000;
  localparam int TPUR_CYC = CLK_HZ / 1000000 * TPUR_US;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    PS_SLEEP, PS_RAMP, PS_NORMAL, PS_AFTERRUN, PS_AR_RESET,
    PS_POWERDOWN, PS_WAKECLR
  } epsrs_state_t;
endpackage

// ==== rtl/epsrs_supervisor.sv ====
// power-state tail, reset sources and power-stage gating
`timescale 1ns/100ps
// Contract
// - power-down timer overflow in power-down moves to wake-clear, clears wakes
// - wake-clear with key low enters sleep
// - wake is OR of pin, bus and engine-off-timer wake flags
// - status bit 1 shows ramp-up, normal, afterrun or power-down state
// - power-down timer length comes from the config time field
// - internal power-on reset clears all, then sleep or ramp-up
// - 5 V regulators stay off until internal supply is good
// - ECU power-on reset holds reset and monitor low until delay passes
// - main supply undervoltage holds pins low; delayed switch-off stays
// - main relay follows key, wake pin and battery, not reset
// - tracker faults only set diagnosis bits
// - main supply overvoltage disables outside functions, pins low
// - battery overvoltage disables power stages
// - enabled watchdog reset: reset pin low, stages off, bus receive-only
// - software reset write resets device and bumps power-down counter
// - forced low on reset pin resets the device
// - monitor low clears channel and ignition enables; host re-enables
// - serial timeout clears stage enables; host re-enables after frame
// - afterrun reset bit set and afterrun-to-normal fires afterrun reset
// - entering wake-clear runs the wake clear per command bit
// - afterrun reset state goes to normal on next clock
module epsrs_supervisor (
  input wire logic clk,
  input wire logic rst,
  input wire logic intPorActive,
  input wire logic keyHigh,
  input wire logic wake_pin_flag,
  input wire logic bus_wake_flag,
  input wire logic engine_off_timer_wake_flag,
  input wire logic rampTimerOverflow,
  input wire logic main5vAboveUv,
  input wire logic main5vAboveHyst,
  input wire logic main5vOverVolt,
  input wire logic tracker_supply_one_uv,
  input wire logic tracker_supply_one_ov,
  input wire logic tracker_supply_two_uv,
  input wire logic tracker_supply_two_ov,
  input wire logic batOverVolt,
  input wire logic batSupplyOk,
  input wire logic pdCounterOverflow,
  input wire logic secureShutoffOverflow,
  input wire logic wdResetIncrement,
  input wire logic serialTimeout,
  input wire logic serialFrameValid,
  input wire logic resetPinIn,
  input wire logic monitorPinIn,
  input wire logic resetPinOut,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic resetPinOe,
  output logic monitorPinOut,
  output logic monitorPinOe,
  output logic regulator5vEn,
  output logic powerStageEn,
  output logic delayedSwitchOffEn,
  output logic externalCommEn,
  output logic linCanRxOnly,
  output logic mainRelayOn,
  output logic wakeClearPulse,
  output logic [epsrs_pkg::NUM_CH-1:0] output_channel_enable,
  output logic [epsrs_pkg::NUM_IGN-1:0] ignition_driver_enable,
  output logic [7:0] pdCount
);
  import epsrs_pkg::*;

  typedef struct packed {
    epsrs_state_t st;
    logic [31:0] cfg;
    logic [31:0] cmd;
    logic [NUM_CH-1:0] chEn;
    logic [NUM_IGN-1:0] ignEn;
    logic [3:0] diag;
    logic [CNT_W-1:0] pdtCyc;
    logic [PDT_W-1:0] pdtCnt;
    logic pdtOf;
    logic [CNT_W-1:0] tpurCnt;
    logic porHold;
    logic timeoutLock;
    logic [7:0] pdCnt;
    logic [1:0] rstSync;
    logic [1:0] monSync;
    logic rstPrevLow;
    logic monPrevLow;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic rstOe;
    logic monOe;
    logic reg5v;
    logic stageEn;
    logic dsoEn;
    logic extEn;
    logic rxOnly;
    logic relay;
    logic wake_clear_command_bit;
    logic [2:0] rstOeHist;
    logic [2:0] monOeHist;
    logic [NUM_CH-1:0] chOut;
    logic [NUM_IGN-1:0] ignOut;
  } epsrs_regs_t;

  epsrs_regs_t r;
  epsrs_regs_t next_r;
  logic wake;
  logic devReset;
  logic apbAcc;
  logic apbDone;

  always_comb begin
    next_r = r;
    wake = wake_pin_flag | bus_wake_flag | engine_off_timer_wake_flag;
    apbAcc = psel & penable & ~r.ready;
    apbDone = psel & penable & r.ready;
    next_r.ready = apbAcc;
    next_r.slverr = 1'b0;
    next_r.wake_clear_command_bit = 1'b0;
    next_r.rstSync = {r.rstSync[0], resetPinIn};
    next_r.monSync = {r.monSync[0], monitorPinIn};
    next_r.rstPrevLow = ~r.rstSync[1];
    next_r.monPrevLow = ~r.monSync[1];
    // own drive echoes through the sync, so mask it a while
    next_r.rstOeHist = {r.rstOeHist[1:0], r.rstOe};
    next_r.monOeHist = {r.monOeHist[1:0], r.monOe};
    devReset = 1'b0;
    // external low on reset pin, not self-driven
    if (~r.rstSync[1] & ~r.rstPrevLow & ~r.rstOe &
        (r.rstOeHist == 3'b000)) begin
      devReset = 1'b1;
    end
    if (apbAcc) begin
      next_r.rdata = 32'h0000_0000;
      case (paddr)
        OFS_OP_CONFIG: next_r.rdata = r.cfg;
        OFS_OP_STATUS: begin
          // mode bit: 1 afterrun, bit1 set in ramp, normal, afterrun and power-down; state code ORed into bits 3:1
          next_r.rdata = {24'h000000, 4'h0, r.st, 1'b0} |
            {30'h00000000, (r.st == PS_NORMAL) | (r.st == PS_AFTERRUN),
            r.st == PS_AFTERRUN};
        end
        OFS_SW_RESET: next_r.rdata = 32'h0000_0000;
        OFS_CMD: next_r.rdata = r.cmd;
        OFS_STAGE_EN: next_r.rdata = {8'h00, r.chEn};
        OFS_IGN_EN: next_r.rdata = {28'h0000000, r.ignEn};
        OFS_DIAG: next_r.rdata = {24'h000000, r.pdCnt[3:0], r.diag};
        default: next_r.slverr = 1'b1;
      endcase
    end
    // writes land at the completing edge only
    if (apbDone & pwrite) begin
      case (paddr)
        OFS_OP_CONFIG: next_r.cfg = pwdata;
        OFS_SW_RESET: devReset = 1'b1;
        OFS_CMD: next_r.cmd = pwdata;
        OFS_STAGE_EN: begin
          if (~r.timeoutLock) next_r.chEn = pwdata[NUM_CH-1:0];
        end
        OFS_IGN_EN: begin
          if (~r.timeoutLock) next_r.ignEn = pwdata[NUM_IGN-1:0];
        end
        OFS_DIAG: next_r.diag = r.diag & ~pwdata[3:0];
        default: next_r.slverr = 1'b0;
      endcase
    end
    // tracker faults: diagnosis only, set wins over clear
    next_r.diag = next_r.diag | {tracker_supply_two_ov,
      tracker_supply_two_uv, tracker_supply_one_ov, tracker_supply_one_uv};
    if (serialFrameValid) next_r.timeoutLock = 1'b0;
    if (serialTimeout) begin
      next_r.chEn = '0;
      next_r.ignEn = '0;
      next_r.timeoutLock = 1'b1;
    end
    if (~r.monSync[1] & ~r.monPrevLow & ~r.monOe &
        (r.monOeHist == 3'b000)) begin
      next_r.chEn = '0;
      next_r.ignEn = '0;
    end
    // power-down timer, units of PDT_UNIT_CYC
    if (r.st == PS_POWERDOWN) begin
      if (r.pdtCyc == CNT_W'(PDT_UNIT_CYC - 1)) begin
        next_r.pdtCyc = '0;
        if (r.pdtCnt >= r.cfg[CFG_PDT_LSB +: PDT_W]) begin
          next_r.pdtOf = 1'b1;
        end else begin
          next_r.pdtCnt = r.pdtCnt + 1'b1;
        end
      end else begin
        next_r.pdtCyc = r.pdtCyc + 1'b1;
      end
    end else begin
      next_r.pdtCyc = '0;
      next_r.pdtCnt = '0;
      next_r.pdtOf = 1'b0;
    end
    case (r.st)
      PS_SLEEP: if (keyHigh | wake) next_r.st = PS_RAMP;
      PS_RAMP: begin
        if ((keyHigh | wake) & main5vAboveUv) begin
          next_r.st = PS_NORMAL;
          next_r.porHold = 1'b1;
          next_r.tpurCnt = '0;
        end else if (~keyHigh & wake & rampTimerOverflow) begin
          next_r.st = PS_WAKECLR;
          next_r.wake_clear_command_bit = r.cmd[CMD_WAKE_CLEAR_COMMAND_BIT_BIT];
        end else if (~keyHigh & ~wake) begin
          next_r.st = PS_SLEEP;
        end
      end
      PS_NORMAL: begin
        if ((pdCounterOverflow | secureShutoffOverflow) & ~keyHigh) begin
          next_r.st = PS_POWERDOWN;
        end else if (~keyHigh & r.cfg[CFG_AE_BIT]) begin
          next_r.st = PS_AFTERRUN;
        end else if (~keyHigh & ~wake) begin
          next_r.st = PS_SLEEP;
        end
      end
      PS_AFTERRUN: begin
        if (pdCounterOverflow | secureShutoffOverflow) begin
          next_r.st = PS_POWERDOWN;
        end else if (keyHigh) begin
          next_r.st = r.cfg[CFG_AR_BIT] ? PS_AR_RESET : PS_NORMAL;
        end else if (~r.cfg[CFG_AE_BIT] & ~wake) begin
          next_r.st = PS_SLEEP;
        end
      end
      PS_AR_RESET: next_r.st = PS_NORMAL;
      PS_POWERDOWN: begin
        if (r.pdtOf) begin
          next_r.st = PS_WAKECLR;
          next_r.wake_clear_command_bit = r.cmd[CMD_WAKE_CLEAR_COMMAND_BIT_BIT];
        end
      end
      PS_WAKECLR: begin
        next_r.st = keyHigh ? PS_RAMP : PS_SLEEP;
      end
      default: next_r.st = PS_SLEEP;
    endcase
    // power-up reset delay once above hysteresis
    if (r.porHold) begin
      if (~main5vAboveHyst) begin
        next_r.tpurCnt = '0;
      end else if (r.tpurCnt == CNT_W'(TPUR_CYC - 1)) begin
        next_r.porHold = 1'b0;
      end else begin
        next_r.tpurCnt = r.tpurCnt + 1'b1;
      end
    end
    // device reset keeps power-down counter; only a software reset write bumps it
    if (devReset | (r.st == PS_AR_RESET)) begin
      next_r.cfg = CFG_RESET;
      next_r.cmd = CMD_RESET;
      next_r.chEn = '0;
      next_r.ignEn = '0;
      next_r.porHold = 1'b1;
      next_r.tpurCnt = '0;
    end
    if (apbDone & pwrite & (paddr == OFS_SW_RESET)) begin
      next_r.pdCnt = r.pdCnt + 8'h01;
    end
    // undervoltage pulls pins, delayed off stays
    // overvoltage pulls pins, blocks outside functions
    next_r.rstOe = next_r.porHold | ~main5vAboveUv | main5vOverVolt |
      (wdResetIncrement & r.cfg[CFG_WATCHDOG_RESET_ENABLE_BIT]);
    next_r.monOe = next_r.porHold | ~main5vAboveUv | main5vOverVolt;
    next_r.extEn = ~main5vOverVolt & ~next_r.porHold & main5vAboveUv;
    next_r.stageEn = ~(next_r.rstOe | next_r.monOe | batOverVolt);
    next_r.chOut = next_r.chEn & {NUM_CH{next_r.stageEn}};
    next_r.ignOut = next_r.ignEn & {NUM_IGN{next_r.stageEn}};
    next_r.rxOnly = next_r.rstOe & ~main5vOverVolt;
    next_r.dsoEn = ~batOverVolt & ~next_r.porHold;
    // relay from key, wake pin, battery
    next_r.relay = (keyHigh | wake_pin_flag) & batSupplyOk;
    next_r.reg5v = ~intPorActive;
    // internal power-on reset, then sleep or ramp
    if (intPorActive) begin
      next_r = '0;
      next_r.st = (keyHigh | wake) ? PS_RAMP : PS_SLEEP;
      next_r.cmd = CMD_RESET;
      next_r.porHold = 1'b1;
      next_r.rstOe = 1'b1;
      next_r.monOe = 1'b1;
      next_r.rstSync = 2'b11;
      next_r.monSync = 2'b11;
      next_r.relay = (keyHigh | wake_pin_flag) & batSupplyOk;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= PS_SLEEP;
      r.cmd <= CMD_RESET;
      r.porHold <= 1'b1;
      r.rstOe <= 1'b1;
      r.monOe <= 1'b1;
      r.rstSync <= 2'b11;
      r.monSync <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign resetPinOe = r.rstOe;
  assign monitorPinOut = 1'b0;
  assign monitorPinOe = r.monOe;
  assign regulator5vEn = r.reg5v;
  assign powerStageEn = r.stageEn;
  assign delayedSwitchOffEn = r.dsoEn;
  assign externalCommEn = r.extEn;
  assign linCanRxOnly = r.rxOnly;
  assign mainRelayOn = r.relay;
  assign wakeClearPulse = r.wake_clear_command_bit;
  assign output_channel_enable = r.chOut;
  assign ignition_driver_enable = r.ignOut;
  assign pdCount = r.pdCnt;
endmodule

// ==== tb/epsrs_host_model.sv ====
// host-side model of the open-drain reset and monitor lines
`timescale 1ns/100ps
module epsrs_host_model (
  input wire logic resetPinOe,
  input wire logic monitorPinOe,
  input wire logic pullRst,
  input wire logic pullMon,
  output logic resetPinIn,
  output logic monitorPinIn
);
  // host or neighbours pull low
  // pull-up on both lines, any low driver wins
  assign resetPinIn = !(resetPinOe || pullRst);
  assign monitorPinIn = !(monitorPinOe || pullMon);
endmodule

// ==== tb/epsrs_monitor.sv ====
// assertions on the supervisor ports
`timescale 1ns/100ps
module epsrs_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic intPorActive,
  input wire logic main5vAboveUv,
  input wire logic main5vOverVolt,
  input wire logic batOverVolt,
  input wire logic monitorPinIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic resetPinOe,
  input wire logic monitorPinOe,
  input wire logic regulator5vEn,
  input wire logic powerStageEn,
  input wire logic externalCommEn,
  input wire logic wakeClearPulse,
  input wire logic [epsrs_pkg::NUM_CH-1:0] output_channel_enable,
  input wire logic [epsrs_pkg::NUM_IGN-1:0] ignition_driver_enable,
  input wire logic [7:0] pdCount
);
  import epsrs_pkg::*;
  logic [7:0] expPd;
  logic swr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign swr = psel && penable && pready && pwrite && paddr == OFS_SW_RESET;
  // count taken at the completing edge, seen a cycle later
  always_ff @(posedge clk) begin
    if (swr) begin
      expPd <= pdCount + 8'h01;
    end
  end
  chk_ov_shutoff: assert property (main5vOverVolt[*2] |-> resetPinOe &&
    monitorPinOe && !powerStageEn && !externalCommEn)
    else $error("main overvoltage left outputs active");
  chk_uv_pins: assert property (!main5vAboveUv[*2] |->
    resetPinOe && monitorPinOe) else $error("undervoltage released pins");
  chk_bat_stage: assert property (batOverVolt[*2] |-> !powerStageEn)
    else $error("battery overvoltage left stages on");
  chk_gate_enables: assert property (!powerStageEn[*2] |->
    output_channel_enable == '0 && ignition_driver_enable == '0)
    else $error("enables active with stages off");
  chk_mon_clear: assert property ((!monitorPinIn && !monitorPinOe)[*4]
    |-> output_channel_enable == '0 && ignition_driver_enable == '0)
    else $error("monitor low did not clear enables");
  chk_por_regs: assert property (intPorActive[*2] |-> !regulator5vEn &&
    resetPinOe && monitorPinOe) else $error("power-on reset not applied");
  chk_sr_count: assert property (swr |-> ##[1:3] pdCount == expPd)
    else $error("software reset not counted");
  chk_wake_clear_command_bit_once: assert property (wakeClearPulse |=> !wakeClearPulse)
    else $error("wake clear pulse too long");
endmodule
bind epsrs_supervisor epsrs_monitor epsrs_monitor_inst (.*);

// ==== tb/test_epsrs_supervisor.sv ====
// self-checking bench for the power-state and reset supervisor
`timescale 1ns/100ps
module test_epsrs_supervisor;
  import epsrs_pkg::*;
  logic clk, rst, intPorActive, main5vAboveUv, main5vOverVolt, batOverVolt;
  logic pdCounterOverflow, psel, penable, pwrite, pullRst, pullMon, se;
  logic keyHigh, wake_pin_flag, bus_wake_flag, engine_off_timer_wake_flag;
  logic tracker_supply_one_uv, tracker_supply_one_ov;
  logic tracker_supply_two_uv, tracker_supply_two_ov;
  logic wdResetIncrement, serialTimeout, serialFrameValid, main5vAboveHyst;
  logic pready, pslverr, resetPinOe, monitorPinOut, monitorPinOe;
  logic regulator5vEn, powerStageEn, delayedSwitchOffEn, externalCommEn;
  logic linCanRxOnly, mainRelayOn, wakeClearPulse, resetPinIn, monitorPinIn;
  logic [NUM_CH-1:0] output_channel_enable;
  logic [NUM_IGN-1:0] ignition_driver_enable;
  logic [3:0] wk, trk;
  logic [2:0] pv;
  logic [7:0] paddr, pdCount, pd;
  logic [31:0] pwdata, prdata, q, r;
  int err_count, checks, i;
  // unused pin input, absent overflow sources, battery supply held good
  wire logic resetPinOut = 1'b0;
  wire logic rampTimerOverflow = 1'b0;
  wire logic secureShutoffOverflow = 1'b0;
  wire logic batSupplyOk = 1'b1;
  assign main5vAboveHyst = main5vAboveUv;
  assign {keyHigh, engine_off_timer_wake_flag, bus_wake_flag,
    wake_pin_flag} = wk;
  assign {tracker_supply_one_uv, tracker_supply_one_ov,
    tracker_supply_two_uv, tracker_supply_two_ov} = trk;
  assign {wdResetIncrement, serialTimeout, serialFrameValid} = pv;
  epsrs_supervisor epsrs_supervisor_inst (.*);
  epsrs_host_model epsrs_host_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test;
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] o);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    o = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(1'b0, 1'b1);
      finish_test;
    end
  endtask
  // state moves take a few cycles, so poll the status bit
  task automatic wst(input int b, input logic v);
    logic [31:0] s;
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, OFS_OP_STATUS, 32'h0, s);
      if (s[b] === v) break;
    end
    check(s[b], v);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pv <= 3'(1 << b);
    @(posedge clk);
    pv <= 3'h0;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    check(1'b0, 1'b1);
    finish_test;
  end
  initial begin
    void'($urandom(32'hC3AF3C99));
    rst = 1'b1;
    {intPorActive, main5vAboveUv, main5vOverVolt, batOverVolt, pullMon,
      pdCounterOverflow, psel, penable, pwrite, pullRst} = '0;
    {wk, trk, pv, paddr, pwdata} = '0;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(resetPinOe, 1'b1);
    check(regulator5vEn, 1'b0);
    apb(1'b0, OFS_OP_CONFIG, 32'h0, q);
    check(q, CFG_RESET);
    apb(1'b0, OFS_CMD, 32'h0, q);
    check(q, CMD_RESET);
    apb(1'b0, 8'h1C, 32'h0, q);
    check(se, 1'b1);
    wk <= 4'($urandom);
    intPorActive <= 1'b1;
    repeat (3) @(posedge clk);
    check(regulator5vEn, 1'b0);
    intPorActive <= 1'b0;
    wk <= 4'h0;
    main5vAboveUv <= 1'b1;
    wst(1, 1'b0);
    for (i = 0; i < 4; i++) begin
      wk <= 4'(1 << i);
      wst(1, 1'b1);
      wk <= 4'h0;
      wst(1, 1'b0);
    end
    pd = pdCount;
    apb(1'b1, OFS_SW_RESET, $urandom, q);
    repeat (4) @(posedge clk);
    check(pdCount, pd + 8'h01);
    wk <= 4'h8;
    wst(1, 1'b1);
    r = (32'h1 << CFG_AR_BIT) | (32'h1 << CFG_AE_BIT);
    apb(1'b1, OFS_OP_CONFIG, r, q);
    wk <= 4'h0;
    wst(0, 1'b1);
    wk <= 4'h8;
    wst(0, 1'b0);
    apb(1'b0, OFS_OP_CONFIG, 32'h0, q);
    check(q, CFG_RESET);
    r = 32'($urandom) & 32'h00FF_FFFF;
    apb(1'b1, OFS_STAGE_EN, r, q);
    apb(1'b0, OFS_STAGE_EN, 32'h0, q);
    check(q, r);
    pulse(1);
    apb(1'b0, OFS_STAGE_EN, 32'h0, q);
    check(q, 32'h0);
    apb(1'b1, OFS_STAGE_EN, r, q);
    apb(1'b0, OFS_STAGE_EN, 32'h0, q);
    check(q, 32'h0);
    pulse(0);
    apb(1'b1, OFS_STAGE_EN, r, q);
    apb(1'b0, OFS_STAGE_EN, 32'h0, q);
    check(q, r);
    apb(1'b1, OFS_OP_CONFIG, 32'h1 << CFG_WATCHDOG_RESET_ENABLE_BIT, q);
    pulse(2);
    repeat (2) @(posedge clk);
    check(linCanRxOnly, 1'b1);
    check(powerStageEn, 1'b0);
    trk <= 4'($urandom) | 4'h1;
    wst(1, 1'b1);
    apb(1'b0, OFS_DIAG, 32'h0, q);
    check(q[3:0], {trk[0], trk[1], trk[2], trk[3]});
    trk <= 4'h0;
    // one fault at a time, each replaces the last
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      main5vOverVolt <= (i == 0);
      main5vAboveUv <= (i != 1);
      batOverVolt <= (i == 2);
      pullMon <= (i == 3);
      repeat (6) @(posedge clk);
      check(mainRelayOn, 1'b1);
    end
    {main5vOverVolt, batOverVolt, pullMon} <= 3'h0;
    wst(1, 1'b1);
    // shortest time field keeps the run within budget
    apb(1'b1, OFS_OP_CONFIG, 32'h0, q);
    wk <= 4'h4;
    pdCounterOverflow <= 1'b1;
    repeat (3) @(posedge clk);
    wk <= 4'h0;
    pdCounterOverflow <= 1'b0;
    i = 0;
    while (wakeClearPulse !== 1'b1 && i < 50000) begin
      @(posedge clk);
      i++;
    end
    check(wakeClearPulse, 1'b1);
    check(i >= PDT_UNIT_CYC - 8 && i <= PDT_UNIT_CYC + 8, 1'b1);
    wst(1, 1'b0);
    finish_test;
  end
endmodule
